// ---- hw/dirp_dll_core.sv ----
`timescale 1ns/1ps
`default_nettype none

module dirp_dll_core
    import dirp_pkg::*;
#(
    parameter int unsigned TAP_W    = 8,
    parameter int unsigned STEP_DIV = STEP_DIV_CYC
) (
    input  wire logic             mclk,
    input  wire logic             rst_b,
    input  wire logic             soft_reset,
    input  wire logic             hold_en,
    input  wire logic             manual_en,
    input  wire logic [TAP_W-1:0] manual_tap,
    input  wire logic             phase_zero,
    input  wire logic             phase_lead,
    output logic      [TAP_W-1:0] tap_q,
    output logic                  run_q,
    output logic                  range_fault_q,
    output logic                  tap_change_q
);

    localparam int unsigned      DIV_W    = $clog2(STEP_DIV) + 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(STEP_DIV - 1);
    localparam logic [TAP_W-1:0] TAP_MAX  = '1;
    localparam logic [TAP_W-1:0] TAP_MIN  = '0;

    logic [DIV_W-1:0] div_cnt_q;
    logic [DIV_W-1:0] div_cnt_d;
    logic [TAP_W-1:0] tap_d;
    logic [3:0]       chg_cnt_q;
    logic [3:0]       chg_cnt_d;
    logic             walk_q;
    logic             walk_d;
    logic             run_d;
    logic             err_d;

    // The step divider sets the tap slew; one step per STEP_DIV cycles.
    wire step_en   = (div_cnt_q == DIV_LAST);
    wire at_max    = (tap_q == TAP_MAX);
    wire at_min    = (tap_q == TAP_MIN);
    wire frozen    = hold_en & run_q;                         // see RL8
    wire tracking  = step_en & ~walk_q & ~manual_en & ~frozen & ~phase_zero;
    wire go_up     = tracking & phase_lead & ~at_max;
    wire go_dn     = tracking & ~phase_lead & ~at_min;
    wire overrun   = tracking & (phase_lead ? at_max : at_min);
    wire walk_dn   = step_en & walk_q & ~at_min & ~manual_en; // see RL13
    wire lock_seen = step_en & ~walk_q & ~manual_en & phase_zero;
    wire moved     = (tap_d != tap_q);

    // Manual tap overrides the detector; otherwise step up or down.
    assign tap_d = manual_en ? manual_tap :                  // see RL9 RL12
                   go_up ? tap_q + 1'b1 :
                   (go_dn | walk_dn) ? tap_q - 1'b1 : tap_q;
    assign div_cnt_d = step_en ? '0 : div_cnt_q + 1'b1;
    assign walk_d    = soft_reset | (walk_q & ~at_min & ~manual_en);
    // Lock status is sticky; only reset or a soft reset drops it.
    assign run_d     = soft_reset ? 1'b0 : (run_q | lock_seen); // see RL16
    // Running off either end flags a fault until lock is found again or a soft reset clears it.
    assign err_d     = (soft_reset | lock_seen) ? 1'b0 :
                       (overrun | range_fault_q);
    assign chg_cnt_d = moved ? CHANGE_HOLD_CYC :              // see RL18
                       (chg_cnt_q != 4'h0) ? chg_cnt_q - 4'h1 : 4'h0;

    // Loop state registers.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt_q     <= '0;
            tap_q         <= TAP_MIN;
            walk_q        <= 1'b0;
            run_q         <= 1'b0;
            range_fault_q <= 1'b0;
            chg_cnt_q     <= 4'h0;
            tap_change_q  <= 1'b0;
        end else begin
            div_cnt_q     <= div_cnt_d;
            tap_q         <= tap_d;
            walk_q        <= walk_d;
            run_q         <= run_d;
            range_fault_q <= err_d;
            chg_cnt_q     <= chg_cnt_d;
            tap_change_q  <= (chg_cnt_d != 4'h0);
        end
    end

    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    property p_run_sticky;
        run_q && !soft_reset |=> run_q;
    endproperty
    a_run_sticky: assert property (p_run_sticky) // see RL16
        else $error("lock status dropped without reset");

    // A move retriggers the flag, so the length is checked from the last
    // move: high for eight cycles after it, and low only nine after it.
    property p_change_pulse;
        moved |=> tap_change_q [*8];
    endproperty
    a_change_pulse: assert property (p_change_pulse) // see RL18
        else $error("tap change flag not high for eight cycles");

    property p_change_end;
        $fell(tap_change_q) |-> $past(moved, 9);
    endproperty
    a_change_end: assert property (p_change_end) // see RL18
        else $error("tap change flag dropped at the wrong time");

    property p_manual_tap;
        manual_en |=> tap_q == $past(manual_tap);
    endproperty
    a_manual_tap: assert property (p_manual_tap) // see RL9
        else $error("manual tap not applied");

    property p_hold_freeze;
        hold_en && run_q && !manual_en && !soft_reset |=> $stable(tap_q);
    endproperty
    a_hold_freeze: assert property (p_hold_freeze) // see RL8
        else $error("tap moved while held after lock");

endmodule

`default_nettype wire

// ---- hw/dirp_pkg.sv ----
`default_nettype none

// Shared constants of the indirect register port and the delay loop.
package dirp_pkg;

    // Host side decode of the command word register.
    localparam int unsigned HOST_ADDR_W   = 12;
    localparam logic [11:0] CMD_PORT_ADDR = 12'hA00;

    // Field positions inside the 32-bit command word.
    localparam int unsigned CMD_BUSY_BIT  = 31;
    localparam int unsigned CMD_DIR_BIT   = 30;
    localparam int unsigned CMD_TGT_HI    = 15;
    localparam int unsigned CMD_TGT_LO    = 14;
    localparam int unsigned CMD_NORM_BIT  = 13;
    localparam int unsigned CMD_TSTB_BIT  = 11;
    localparam int unsigned CMD_DATA_HI   = 7;
    localparam logic        CMD_DIR_WRITE = 1'b0;
    localparam logic        CMD_DIR_READ  = 1'b1;
    localparam logic        CMD_TSTB_RST  = 1'b1;

    // Loop register addresses on the two-bit indirect address.
    localparam logic [1:0]  LREG_CFG      = 2'h0;
    localparam logic [1:0]  LREG_MANUAL   = 2'h1;
    localparam logic [1:0]  LREG_TAP      = 2'h2;
    localparam logic [1:0]  LREG_STATUS   = 2'h3;

    // Configuration register layout and reset values.
    localparam int unsigned CFG_HOLD_BIT   = 0;
    localparam int unsigned CFG_MANUAL_BIT = 1;
    localparam int unsigned CFG_IRQEN_BIT  = 2;
    localparam int unsigned CFG_BYPASS_BIT = 4;
    localparam logic [7:0]  CFG_RW_MASK    = 8'h37;
    localparam logic [7:0]  CFG_RST        = 8'h00;
    localparam logic [7:0]  MANUAL_TAP_RST = 8'h00;

    // Status register layout.
    localparam int unsigned STS_RUN_BIT     = 0;
    localparam int unsigned STS_CHANGE_BIT  = 1;
    localparam int unsigned STS_ERROR_BIT   = 2;
    localparam int unsigned STS_CHANGEI_BIT = 4;
    localparam int unsigned STS_RANGE_FAULT_EVENT_BIT  = 5;
    localparam int unsigned STS_REFI_BIT    = 6;
    localparam int unsigned STS_SYSI_BIT    = 7;

    // Loop timing: a soft reset walks down and back within this budget.
    localparam int unsigned TAP_COUNT        = 256;
    localparam int unsigned SOFT_RST_BUDGET  = 24 * 256;
    localparam int unsigned STEP_DIV_CYC     = SOFT_RST_BUDGET
                                               / (2 * TAP_COUNT);
    localparam logic [3:0]  CHANGE_HOLD_CYC  = 4'h8;

    // Command sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_DONE = 3'b100
    } dirp_cmd_state_t;

endpackage

`default_nettype wire

// ---- hw/dirp_top.sv ----
// Notes on behaviour
// RL1: Host waits after command write until busy clears.
// RL2: Direction bit zero writes, one reads.
// RL3: Busy set runs command, cleared when finished.
// RL4: Payload byte supplies write data, receives read.
// RL5: Two-bit address selects the loop register.
// RL6: Host sets test-select bit in normal mode.
// RL7: Production strobe active low, resets high.
// RL8: Hold bit freezes tap after first lock.
// RL9: Manual enable bypasses detector, uses manual tap.
// RL10: Fault interrupt only when its enable is high.
// RL11: Bypass bit selects plain buffered system clock.
// RL12: Manual tap zero minimum, 255 maximum delay.
// RL13: Writing tap status soft-resets the loop.
// RL14: Tap status shows tap in use.
// RL15: Loop registers at 0x00, 0x01, 0x02.
// RL16: Lock bit sticky until reset or soft reset.
// RL17: Fault event sets on rise, clears on read.
// RL18: Tap change flag high eight cycles.
// RL19: Read data loaded no later than busy clear.
// RL20: Host issues no command while busy.
`timescale 1ns/1ps
`default_nettype none

module dirp_top
    import dirp_pkg::*;
#(
    parameter int unsigned TAP_W    = 8,
    parameter int unsigned STEP_DIV = STEP_DIV_CYC
) (
    input  wire logic                   mclk,
    input  wire logic                   rst_b,
    input  wire logic                   host_sel,
    input  wire logic                   host_wr,
    input  wire logic                   host_rd,
    input  wire logic [HOST_ADDR_W-1:0] host_addr,
    input  wire logic [31:0]            host_wdata,
    input  wire logic                   phase_zero,
    input  wire logic                   phase_lead,
    input  wire logic                   reference_clock,
    output logic      [31:0]            host_rdata_q,
    output logic                        host_wait_q,
    output logic                        aligned_clock_bypass_q,
    output logic      [TAP_W-1:0]       delay_tap_q,
    output logic                        range_fault_irq_q
);

    dirp_cmd_state_t state_q;
    dirp_cmd_state_t state_d;

    logic             cmd_busy_q;
    logic             cmd_busy_d;
    logic             cmd_direction_q;
    logic [1:0]       cmd_target_sel_q;
    logic             normal_access_select_q;
    logic             prod_test_strobe_n_q;
    logic [7:0]       cmd_payload_q;
    logic [7:0]       cmd_payload_d;
    logic [31:0]      host_rdata_d;
    logic             host_wait_d;
    logic [7:0]       cfg_q;
    logic [7:0]       manual_tap_q;
    logic             soft_reset_q;
    logic             ref_prev_q;
    logic             change_prev_q;
    logic             fault_prev_q;
    logic             tap_change_event_q;
    logic             range_fault_event_q;
    logic             ref_event_q;
    logic             sys_event_q;
    logic             core_run;
    logic             core_fault;
    logic             core_change;
    logic [7:0]       loop_rdata;
    logic [7:0]       status_byte;
    logic [31:0]      cmd_word;

    ////////////////////////////////////////////////////////////////////////
    // Host access decode.

    // Accesses made while the wait line is up are not taken at all.
    wire host_write = host_sel & host_wr & ~host_wait_q;      // see RL1
    wire host_read  = host_sel & host_rd & ~host_wait_q;
    wire cmd_hit    = (host_addr == CMD_PORT_ADDR);
    wire cmd_wr     = host_write & cmd_hit;
    // A new command is taken only from idle, when the port is free.
    wire start_cmd  = cmd_wr & host_wdata[CMD_BUSY_BIT]
                      & (state_q == ST_IDLE);                 // see RL20
    wire st_exec    = (state_q == ST_EXEC);
    wire st_done    = (state_q == ST_DONE);

    // Loop side strobes, issued in the single execute cycle.
    wire loop_we    = st_exec & (cmd_direction_q == CMD_DIR_WRITE); // see RL2
    wire loop_re    = st_exec & (cmd_direction_q == CMD_DIR_READ);
    wire we_cfg     = loop_we & (cmd_target_sel_q == LREG_CFG);   // see RL5
    wire we_manual  = loop_we & (cmd_target_sel_q == LREG_MANUAL);
    wire we_tap     = loop_we & (cmd_target_sel_q == LREG_TAP);
    wire rd_clear   = loop_re & (cmd_target_sel_q == LREG_STATUS);

    // Event edges seen against the previous sample.
    wire change_rise = core_change & ~change_prev_q;
    wire fault_rise  = core_fault & ~fault_prev_q;
    wire ref_rise    = reference_clock & ~ref_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // Read paths.

    // Status byte; bit 3 is unused and reads zero.
    assign status_byte = {sys_event_q, ref_event_q, range_fault_event_q,
                          tap_change_event_q, 1'b0, core_fault,
                          core_change, core_run};

    // Tap status is the tap in use; in manual mode it echoes the manual
    // tap and software must treat it as not meaningful.
    assign loop_rdata =                                       // see RL15
        (cmd_target_sel_q == LREG_CFG)    ? (cfg_q & CFG_RW_MASK) :
        (cmd_target_sel_q == LREG_MANUAL) ? manual_tap_q :
        (cmd_target_sel_q == LREG_TAP)    ? delay_tap_q :     // see RL14
                                            status_byte;

    // Command word as the host reads it back; unused bits read zero.
    assign cmd_word = {cmd_busy_q, cmd_direction_q, 14'h0000,
                       cmd_target_sel_q, normal_access_select_q, 1'b0,
                       prod_test_strobe_n_q, 3'h0, cmd_payload_q};

    // Any address other than the command word reads as zero.
    assign host_rdata_d = host_read ? (cmd_hit ? cmd_word : 32'h0000_0000)
                                    : host_rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Command sequencer.

    // Idle, one execute cycle for the loop access, one cycle to finish.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start_cmd) begin
                    state_d = ST_EXEC;
                end
            end
            ST_EXEC: begin
                state_d = ST_DONE;
            end
            ST_DONE: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Busy follows the host write, and is dropped when the command ends.
    assign cmd_busy_d  = cmd_wr ? host_wdata[CMD_BUSY_BIT] :  // see RL3
                         st_done ? 1'b0 : cmd_busy_q;
    assign host_wait_d = start_cmd | (host_wait_q & ~st_done);  // see RL1
    // Read data lands in execute, a cycle before busy falls.
    assign cmd_payload_d = cmd_wr ? host_wdata[CMD_DATA_HI:0] :  // see RL4
                           loop_re ? loop_rdata : cmd_payload_q; // see RL19

    // Sequencer state and host facing outputs.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q      <= ST_IDLE;
            cmd_busy_q   <= 1'b0;
            host_wait_q  <= 1'b0;
            host_rdata_q <= 32'h0000_0000;
        end else begin
            state_q      <= state_d;
            cmd_busy_q   <= cmd_busy_d;
            host_wait_q  <= host_wait_d;
            host_rdata_q <= host_rdata_d;
        end
    end

    // Command fields; the test bits are only stored for read back, as
    // the host is trusted to keep them at their normal levels.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_direction_q        <= CMD_DIR_WRITE;
            cmd_target_sel_q       <= LREG_CFG;
            normal_access_select_q <= 1'b0;
            prod_test_strobe_n_q   <= CMD_TSTB_RST;           // see RL7
            cmd_payload_q          <= 8'h00;
        end else begin
            if (cmd_wr) begin
                cmd_direction_q        <= host_wdata[CMD_DIR_BIT];
                cmd_target_sel_q       <= host_wdata[CMD_TGT_HI:CMD_TGT_LO];
                normal_access_select_q <= host_wdata[CMD_NORM_BIT]; // see RL6
                prod_test_strobe_n_q   <= host_wdata[CMD_TSTB_BIT];
            end
            cmd_payload_q <= cmd_payload_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Loop registers.

    // Configuration and manual tap; a tap status write only pulses the
    // soft reset, it stores nothing.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q        <= CFG_RST;
            manual_tap_q <= MANUAL_TAP_RST;
            soft_reset_q <= 1'b0;
        end else begin
            if (we_cfg) begin
                cfg_q <= cmd_payload_q & CFG_RW_MASK;
            end
            if (we_manual) begin
                manual_tap_q <= cmd_payload_q;                // see RL12
            end
            soft_reset_q <= we_tap;                           // see RL13
        end
    end

    // Event bits: a new edge in the clearing read cycle wins over the
    // clear, so no event is lost to a racing read.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ref_prev_q          <= 1'b0;
            change_prev_q       <= 1'b0;
            fault_prev_q        <= 1'b0;
            tap_change_event_q  <= 1'b0;
            range_fault_event_q <= 1'b0;
            ref_event_q         <= 1'b0;
            sys_event_q         <= 1'b0;
        end else begin
            ref_prev_q          <= reference_clock;
            change_prev_q       <= core_change;
            fault_prev_q        <= core_fault;
            tap_change_event_q  <= change_rise
                                   | (tap_change_event_q & ~rd_clear);
            range_fault_event_q <= fault_rise                 // see RL17
                                   | (range_fault_event_q & ~rd_clear);
            ref_event_q         <= ref_rise | (ref_event_q & ~rd_clear);
            // This logic runs on the system clock, so its activity bit
            // can only ever read back as set.
            sys_event_q         <= 1'b1;
        end
    end

    // Interrupt and clock selection outputs.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            range_fault_irq_q      <= 1'b0;
            aligned_clock_bypass_q <= 1'b0;
        end else begin
            range_fault_irq_q      <= range_fault_event_q     // see RL10
                                      & cfg_q[CFG_IRQEN_BIT];
            aligned_clock_bypass_q <= cfg_q[CFG_BYPASS_BIT];  // see RL11
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Delay loop tap controller.

    dirp_dll_core #(
        .TAP_W    (TAP_W),
        .STEP_DIV (STEP_DIV)
    ) u_core (
        .mclk          (mclk),
        .rst_b         (rst_b),
        .soft_reset    (soft_reset_q),
        .hold_en       (cfg_q[CFG_HOLD_BIT]),
        .manual_en     (cfg_q[CFG_MANUAL_BIT]),
        .manual_tap    (manual_tap_q),
        .phase_zero    (phase_zero),
        .phase_lead    (phase_lead),
        .tap_q         (delay_tap_q),
        .run_q         (core_run),
        .range_fault_q (core_fault),
        .tap_change_q  (core_change)
    );

    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    sequence s_cmd_start;
        start_cmd;
    endsequence

    sequence s_busy_release;
        ##[1:3] !cmd_busy_q;
    endsequence

    property p_busy_clear;
        s_cmd_start |=> s_busy_release;
    endproperty
    a_busy_clear: assert property (p_busy_clear) // see RL3
        else $error("busy flag did not clear after command");

    property p_wait_hold;
        s_cmd_start |=> (host_wait_q && cmd_busy_q) [*2]
                        ##1 (!host_wait_q && !cmd_busy_q);
    endproperty
    a_wait_hold: assert property (p_wait_hold) // see RL1
        else $error("wait state not held exactly while busy");

    property p_read_data;
        $fell(cmd_busy_q) && cmd_direction_q
            |-> cmd_payload_q == $past(loop_rdata, 2);
    endproperty
    a_read_data: assert property (p_read_data) // see RL19
        else $error("read data missing at busy clear");

    property p_manual_write;
        we_manual |=> manual_tap_q == $past(cmd_payload_q);
    endproperty
    a_manual_write: assert property (p_manual_write) // see RL15
        else $error("manual tap register not written");

    property p_soft_reset;
        we_tap |=> soft_reset_q ##1 !core_run;
    endproperty
    a_soft_reset: assert property (p_soft_reset) // see RL13
        else $error("tap status write did not reset the loop");

    property p_fault_event;
        $rose(core_fault) |=> range_fault_event_q;
    endproperty
    a_fault_event: assert property (p_fault_event) // see RL17
        else $error("range fault edge not recorded");

    property p_irq_masked;
        !cfg_q[CFG_IRQEN_BIT] |=> !range_fault_irq_q;
    endproperty
    a_irq_masked: assert property (p_irq_masked) // see RL10
        else $error("interrupt raised while disabled");

    property p_irq_raised;
        range_fault_event_q && cfg_q[CFG_IRQEN_BIT] |=> range_fault_irq_q;
    endproperty
    a_irq_raised: assert property (p_irq_raised) // see RL10
        else $error("enabled range fault raised no interrupt");

endmodule

`default_nettype wire

// ---- tb/dirp_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Host processor model: one access at a time, stalled by the wait state.
module dirp_host_model
    import dirp_pkg::*;
(
    input  wire logic                   mclk,
    input  wire logic                   host_wait_q,
    input  wire logic [31:0]            host_rdata_q,
    output var  logic                   host_sel,
    output var  logic                   host_wr,
    output var  logic                   host_rd,
    output var  logic [HOST_ADDR_W-1:0] host_addr,
    output var  logic [31:0]            host_wdata
);
    int stall_err = 0;

    // The bus starts idle.
    initial begin
        host_sel = 1'b0;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_addr = '0;
        host_wdata = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // The wait state is looked at on the falling edge, where it is settled
    // and equals what the next rising edge samples. Released lines flip.
    task automatic access(input logic wr, input logic [11:0] a,
                          input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk);
        host_sel <= 1'b1;
        host_wr <= wr;
        host_rd <= ~wr;
        host_addr <= a;
        host_wdata <= d;
        @(negedge mclk);
        while (host_wait_q && n < 50) begin
            n++;
            @(negedge mclk);
        end
        if (n == 50) stall_err++;
        @(posedge mclk);
        host_sel <= 1'b0;
        host_wr <= 1'b0;
        host_rd <= 1'b0;
        host_addr <= ~a;
        host_wdata <= ~d;
        @(negedge mclk);
        q = host_rdata_q;
    endtask
endmodule

`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb
    import dirp_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic        phase_zero = 1'b0;
    logic        phase_lead = 1'b0;
    logic        reference_clock = 1'b0;
    logic        host_sel, host_wr, host_rd;
    logic [11:0] host_addr;
    logic [31:0] host_wdata, host_rdata_q;
    logic        host_wait_q, aligned_clock_bypass_q, range_fault_irq_q;
    logic [7:0]  delay_tap_q;
    int          err_count = 0;
    int          total_checks = 0;
    logic [7:0]  taps [3] = '{8'h00, 8'hFF, 8'h03};

    // A short step divider keeps the soft reset walk brief.
    dirp_top #(.TAP_W(8), .STEP_DIV(2)) dut (.mclk(mclk), .rst_b(rst_b),
        .host_sel(host_sel), .host_wr(host_wr), .host_rd(host_rd),
        .host_addr(host_addr), .host_wdata(host_wdata),
        .phase_zero(phase_zero), .phase_lead(phase_lead),
        .reference_clock(reference_clock), .host_rdata_q(host_rdata_q),
        .host_wait_q(host_wait_q),
        .aligned_clock_bypass_q(aligned_clock_bypass_q),
        .delay_tap_q(delay_tap_q), .range_fault_irq_q(range_fault_irq_q));

    dirp_host_model host (.mclk(mclk), .host_wait_q(host_wait_q),
        .host_rdata_q(host_rdata_q), .host_sel(host_sel), .host_wr(host_wr),
        .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata));

    // System clock at 250 MHz; the reference runs at half of it.
    initial forever #2 mclk = ~mclk;
    always @(posedge mclk) reference_clock <= ~reference_clock;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // One indirect command, then a read back of the whole command word.
    task automatic cmd(input logic dir, input logic [1:0] tgt,
                       input logic [7:0] d, output logic [7:0] q);
        logic [31:0] r;
        int n;
        n = 0;
        host.access(1'b1, CMD_PORT_ADDR,
                    {1'b1, dir, 14'h0, tgt, 3'h5, 3'h0, d}, r);
        while (host_wait_q && n < 20) begin
            n++;
            @(negedge mclk);
        end
        check(n, 32'h2);
        host.access(1'b0, CMD_PORT_ADDR, 32'h0, r);
        check({8'h0, r[31:8]}, {9'h0, dir, 14'h0, tgt, 6'h28});
        if (dir == CMD_DIR_WRITE) check(r[7:0], d);
        q = r[7:0];
    endtask

    task automatic complete_run();
        err_count += host.stall_err;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence of register traffic.
    initial begin
        logic [31:0] r;
        logic [7:0]  b;
        logic [7:0]  t;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        host.access(1'b0, CMD_PORT_ADDR, 32'h0, r);
        check(r, 32'h0000_0800);
        host.access(1'b1, 12'h004, 32'hFFFF_FFFF, r);
        host.access(1'b0, 12'h004, 32'h0, r);
        check(r, 32'h0);
        cmd(CMD_DIR_WRITE, LREG_CFG, 8'hFF, b);
        cmd(CMD_DIR_READ, LREG_CFG, 8'h00, b);
        check(b, 8'h37);
        check(aligned_clock_bypass_q, 1'b1);
        foreach (taps[i]) begin
            cmd(CMD_DIR_WRITE, LREG_MANUAL, taps[i], b);
            check(delay_tap_q, taps[i]);
            cmd(CMD_DIR_READ, LREG_TAP, 8'h00, b);
            check(b, taps[i]);
        end
        // Stepping below tap zero raises the fault, with and without irq.
        for (int en = 0; en < 2; en++) begin
            cmd(CMD_DIR_WRITE, LREG_CFG, {5'h0, en[0], 2'h0}, b);
            cmd(CMD_DIR_WRITE, LREG_TAP, 8'h00, b);
            repeat (40) @(posedge mclk);
            check(range_fault_irq_q, en[0]);
            cmd(CMD_DIR_READ, LREG_STATUS, 8'h00, b);
            check(b & 8'hE5, 8'hE4);
            cmd(CMD_DIR_READ, LREG_STATUS, 8'h00, b);
            check(b & 8'h25, 8'h04);
            check(range_fault_irq_q, 1'b0);
        end
        check(aligned_clock_bypass_q, 1'b0);
        @(posedge mclk);
        phase_zero <= 1'b1;
        repeat (8) @(posedge mclk);
        phase_zero <= 1'b0;
        phase_lead <= 1'b1;
        cmd(CMD_DIR_WRITE, LREG_CFG, 8'h01, b);
        t = delay_tap_q;
        cmd(CMD_DIR_READ, LREG_STATUS, 8'h00, b);
        check(b & 8'h05, 8'h01);
        repeat (20) @(posedge mclk);
        check(delay_tap_q, t);
        cmd(CMD_DIR_WRITE, LREG_CFG, 8'h00, b);
        repeat (20) @(posedge mclk);
        check(32'(delay_tap_q == t), 32'h0);
        cmd(CMD_DIR_READ, LREG_STATUS, 8'h00, b);
        check(b & 8'h12, 8'h12);
        complete_run();
    end

    // Watchdog far beyond the few hundred cycles the sequence needs.
    initial begin
        #40000;
        err_count++;
        complete_run();
    end
endmodule

`default_nettype wire
